// *** inc/mrps_regs.vh ***
// register map, field positions, configurations and timing for the selector
//
// Operation
// (RQ1) software enables a channel clock, picks the mode, then pulses reset.
// (RQ2) pins connect to each channel according to the held mode setting.
// (RQ3) both channels in use allow dual RMII only, never MII.
// (RQ4) shared clock pin is channel 0 RX_CLK or REF_CLK, both in dual.
// (RQ5) RMII ignores receive error; dual RMII uses that pin as ch1 CRS_DV.
// (RQ6) MII transmit error pin is high only during low-power idle.
// (RQ7) MII carries the full channel 0 signal set.
// (RQ8) single RMII uses two data bits, CRS_DV, REF_CLK; rest unused.
// (RQ9) dual RMII maps channel 1 onto upper data, error and TX_CLK pins.
// (RQ10) channel 1 absent on single variants; channels independent otherwise.
// (RQ11) stopping a channel clock requires the full setup again.
// (RQ12) MAC internal mode bits are set by software after reset release.
// (RQ13) pins stay enabled and retained in stop and timer modes.
// (RQ14) mode select 0 is MII, 1 RMII; reset bit 1 holds reset.
// (RQ15) software waits for PHY clocks before releasing reset.
// (RQ16) routing changes only while affected channels are held in reset.
// (RQ17) unused outputs drive a fixed low level; unused inputs are ignored.
`ifndef MRPS_REGS_VH
`define MRPS_REGS_VH

`define MRPS_ADDR_W         12
`define MRPS_OFS_MODE       12'h000
`define MRPS_OFS_CLKG       12'h008
`define MRPS_OFS_STAT       12'h00c

`define MRPS_MODE_IFSEL     0
`define MRPS_MODE_MAC0_HW_RESET      1
`define MRPS_MODE_MAC1_HW_RESET      2
`define MRPS_CLKG_EN0       0
`define MRPS_CLKG_EN1       1

`define MRPS_MODE_RESET     3'h6
`define MRPS_CLKG_RESET     2'h0

`define MRPS_CFG_MII        2'h0
`define MRPS_CFG_RMII1      2'h1
`define MRPS_CFG_RMII2      2'h3

`define MRPS_CLK_MHZ        125
`define MRPS_CLK_LOSS_NS    1000
`define MRPS_CLK_LOSS_CYC   ((`MRPS_CLK_LOSS_NS * `MRPS_CLK_MHZ) / 1000)
`define MRPS_LOSS_W         8

`endif

// *** hw/mrps_sync.v ***
// two-stage synchroniser for pin inputs
module mrps_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] meta_r;
  reg [W-1:0] stable_r;

  always @(posedge clk) begin
    if (sys_rst) begin
      meta_r   <= {W{1'b0}};
      stable_r <= {W{1'b0}};
    end else begin
      meta_r   <= din;
      stable_r <= meta_r;
    end
  end

  assign dout = stable_r;
endmodule

// *** hw/mrps_apb_regs.v ***
// APB slave holding the mode and clock gate registers and reading back the status input
`include "mrps_regs.vh"
module mrps_apb_regs (
  input  wire                    clk,
  input  wire                    sys_rst,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`MRPS_ADDR_W-1:0] paddr,
  input  wire [31:0]             pwdata,
  output reg  [31:0]             prdata,
  output reg                     pready,
  output reg                     pslverr,
  input  wire [7:0]              status,
  input  wire                    ch1Present,
  output reg  [2:0]              modeReg_r,
  output reg  [1:0]              clkgReg_r
);
  reg        hit;
  reg [31:0] rdVal;

  always @* begin
    hit   = 1'b1;
    rdVal = 32'h0;
    case (paddr)
      `MRPS_OFS_MODE: rdVal = {29'h0, modeReg_r};
      `MRPS_OFS_CLKG: rdVal = {30'h0, clkgReg_r};
      `MRPS_OFS_STAT: rdVal = {24'h0, status};
      default:        hit   = 1'b0;
    endcase
  end

  // no wait state: setup latches the answer, access completes
  always @(posedge clk) begin
    if (sys_rst) begin
      prdata    <= 32'h0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      modeReg_r <= `MRPS_MODE_RESET;
      clkgReg_r <= `MRPS_CLKG_RESET;
    end else begin
      if (psel && !penable) begin
        pready  <= 1'b1;
        pslverr <= ~hit;
        prdata  <= pwrite ? 32'h0 : rdVal;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
      if (psel && penable && pready && pwrite) begin
        if (paddr == `MRPS_OFS_MODE) begin
          modeReg_r[`MRPS_MODE_IFSEL] <= pwdata[`MRPS_MODE_IFSEL]; // [RQ14]
          modeReg_r[`MRPS_MODE_MAC0_HW_RESET]  <= pwdata[`MRPS_MODE_MAC0_HW_RESET];
          // channel 1 bits stay fixed when the channel is absent
          modeReg_r[`MRPS_MODE_MAC1_HW_RESET]  <= ch1Present ?
                                         pwdata[`MRPS_MODE_MAC1_HW_RESET] : 1'b1; // [RQ10]
        end
        if (paddr == `MRPS_OFS_CLKG) begin
          clkgReg_r[`MRPS_CLKG_EN0] <= pwdata[`MRPS_CLKG_EN0];
          clkgReg_r[`MRPS_CLKG_EN1] <= ch1Present &
                                       pwdata[`MRPS_CLKG_EN1]; // [RQ10]
        end
      end
    end
  end
endmodule

// *** hw/mrps_selector.v ***
// MII / RMII pin selector for one or two MAC channels
//
// Added by the designer: the APB slave port and the register addresses.
`include "mrps_regs.vh"
module mrps_selector #(
  parameter DUAL_CH  = 1,
  parameter LOSS_CYC = `MRPS_CLK_LOSS_CYC
) (
  input  wire                    clk,
  input  wire                    sys_rst,
  // register bus
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`MRPS_ADDR_W-1:0] paddr,
  input  wire [31:0]             pwdata,
  output wire [31:0]             prdata,
  output wire                    pready,
  output wire                    pslverr,
  // chip low-power state (stop or timer mode)
  input  wire                    lowPowerMode,
  // system control towards the MACs
  output reg                     mac0ClockEnable_r,
  output reg                     mac1ClockEnable_r,
  output reg                     mac0HwReset_r,
  output reg                     mac1HwReset_r,
  // channel 0 MAC side
  output reg                     mac0RxClkEn_r,
  output reg                     mac0TxClkEn_r,
  output reg  [3:0]              mac0Rxd_r,
  output reg                     mac0RxDv_r,
  output reg                     mac0RxEr_r,
  output reg                     mac0Crs_r,
  output reg                     mac0Col_r,
  output reg                     mac0MdioIn_r,
  input  wire [3:0]              mac0Txd,
  input  wire                    mac0TxEn,
  input  wire                    mac0LpiActive,
  input  wire                    mac0Mdc,
  input  wire                    mac0MdioOut,
  input  wire                    mac0MdioOe,
  // channel 1 MAC side
  output reg                     mac1RxClkEn_r,
  output reg  [1:0]              mac1Rxd_r,
  output reg                     mac1CrsDv_r,
  output reg                     mac1MdioIn_r,
  input  wire [1:0]              mac1Txd,
  input  wire                    mac1TxEn,
  input  wire                    mac1Mdc,
  input  wire                    mac1MdioOut,
  input  wire                    mac1MdioOe,
  // pins
  input  wire                    sharedRxRefClockPin,
  input  wire [3:0]              rxdPin,
  input  wire                    rxDvPin,
  input  wire                    rxerrOrCh1DvPin,
  input  wire                    crsPin,
  input  wire                    colPin,
  input  wire                    txclkOrCh1MgmtClockPinIn,
  output reg                     txclkOrCh1MgmtClockPinOut_r,
  output reg                     txclkOrCh1MgmtClockPinOe_r,
  output reg  [3:0]              txdPin_r,
  output reg                     txEnPin_r,
  output reg                     txerrOrCh1TxenPin_r,
  output reg                     mdcPin_r,
  input  wire                    mdioPinIn,
  output reg                     mdioPinOut_r,
  output reg                     mdioPinOe_r,
  input  wire                    ch1MgmtDataPinIn,
  output reg                     ch1MgmtDataPinOut_r,
  output reg                     ch1MgmtDataPinOe_r
);
  wire        ch1Present = (DUAL_CH != 0);
  wire [2:0]  interfaceModeRegister;
  wire [1:0]  macClockGateRegister;
  wire [7:0]  status;
  wire [11:0] pinSync;

  wire phyIfSelect     = interfaceModeRegister[`MRPS_MODE_IFSEL];
  wire mac0HwResetBit  = interfaceModeRegister[`MRPS_MODE_MAC0_HW_RESET];
  wire mac1HwResetBit  = interfaceModeRegister[`MRPS_MODE_MAC1_HW_RESET];
  wire mac0ClkEnBit    = macClockGateRegister[`MRPS_CLKG_EN0];
  wire mac1ClkEnBit    = macClockGateRegister[`MRPS_CLKG_EN1] & ch1Present;

  reg [1:0] cfg_r;
  reg       needSetup0_r;
  reg       needSetup1_r;
  reg [1:0] clkPrev_r;
  reg [1:0] clkPresent_r;
  reg       configError_r;

  mrps_apb_regs u_regs (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .status     (status),
    .ch1Present (ch1Present),
    .modeReg_r  (interfaceModeRegister),
    .clkgReg_r  (macClockGateRegister)
  );

  mrps_sync #(
    .W (12)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     ({ch1MgmtDataPinIn, mdioPinIn, colPin, crsPin,
               txclkOrCh1MgmtClockPinIn, rxerrOrCh1DvPin, rxDvPin,
               rxdPin, sharedRxRefClockPin}),
    .dout    (pinSync)
  );

  wire       sRefClk = pinSync[0];
  wire [3:0] sRxd    = pinSync[4:1];
  wire       sRxDv   = pinSync[5];
  wire       sRxErr  = pinSync[6];
  wire       sTxClk  = pinSync[7];
  wire       sCrs    = pinSync[8];
  wire       sCol    = pinSync[9];
  wire       sMdio0  = pinSync[10];
  wire       sMdio1  = pinSync[11];

  wire [1:0] clkSrc  = {sTxClk, sRefClk};
  wire [1:0] clkRise = clkSrc & ~clkPrev_r;

  // clock presence: 0 is the shared receive clock, 1 the MII transmit clock
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_clkdet
      reg [`MRPS_LOSS_W-1:0] lossCnt_r;
      always @(posedge clk) begin
        if (sys_rst) begin
          lossCnt_r        <= {`MRPS_LOSS_W{1'b0}};
          clkPrev_r[gi]    <= 1'b0;
          clkPresent_r[gi] <= 1'b0;
        end else begin
          clkPrev_r[gi] <= clkSrc[gi];
          if (clkRise[gi]) begin
            lossCnt_r        <= {`MRPS_LOSS_W{1'b0}};
            clkPresent_r[gi] <= 1'b1;
          end else if (lossCnt_r == LOSS_CYC[`MRPS_LOSS_W-1:0]) begin
            clkPresent_r[gi] <= 1'b0;
          end else begin
            lossCnt_r <= lossCnt_r + {{(`MRPS_LOSS_W-1){1'b0}}, 1'b1};
          end
        end
      end
    end
  endgenerate

  // requested configuration; MII never pairs with channel 1
  wire       reqDual = phyIfSelect & mac1ClkEnBit;                 // [RQ3]
  wire [1:0] reqCfg  = {reqDual, phyIfSelect};                     // [RQ14]
  wire       isMii   = (cfg_r == `MRPS_CFG_MII);
  wire       isDual  = (cfg_r == `MRPS_CFG_RMII2) & ch1Present;    // [RQ10]
  wire       run0    = mac0ClockEnable_r & ~mac0HwReset_r;
  wire       run1    = mac1ClockEnable_r & ~mac1HwReset_r & isDual;

  wire rst0Eff = mac0HwResetBit | needSetup0_r;
  wire rst1Eff = mac1HwResetBit | needSetup1_r | ~ch1Present;
  wire ch1Touched = cfg_r[1] | reqCfg[1];
  wire cfgMayChange = mac0HwReset_r & (mac1HwReset_r | ~ch1Touched);

  assign status = {1'b0, configError_r, cfg_r, clkPresent_r,
                   needSetup1_r, needSetup0_r};

  // setup tracking and applied routing
  always @(posedge clk) begin
    if (sys_rst) begin
      needSetup0_r      <= 1'b1;
      needSetup1_r      <= 1'b1;
      mac0ClockEnable_r <= 1'b0;
      mac1ClockEnable_r <= 1'b0;
      mac0HwReset_r     <= 1'b1;
      mac1HwReset_r     <= 1'b1;
      cfg_r             <= `MRPS_CFG_MII;
      configError_r     <= 1'b0;
    end else begin
      // a stopped clock forces reset until reset is issued again
      if (!mac0ClkEnBit)
        needSetup0_r <= 1'b1;                                      // [RQ11]
      else if (mac0HwResetBit)
        needSetup0_r <= 1'b0;                                      // [RQ1]
      if (!mac1ClkEnBit)
        needSetup1_r <= 1'b1;                                      // [RQ11]
      else if (mac1HwResetBit)
        needSetup1_r <= 1'b0;
      mac0ClockEnable_r <= mac0ClkEnBit;
      mac1ClockEnable_r <= mac1ClkEnBit;                           // [RQ10]
      mac0HwReset_r     <= rst0Eff;                                // [RQ14]
      mac1HwReset_r     <= rst1Eff;
      if (cfgMayChange)
        cfg_r <= reqCfg;                                           // [RQ16]
      configError_r <= ~phyIfSelect & mac1ClkEnBit;                // [RQ3]
    end
  end

  // receive direction: pins towards the MACs
  always @(posedge clk) begin
    if (sys_rst) begin
      mac0RxClkEn_r <= 1'b0;
      mac0TxClkEn_r <= 1'b0;
      mac0Rxd_r     <= 4'h0;
      mac0RxDv_r    <= 1'b0;
      mac0RxEr_r    <= 1'b0;
      mac0Crs_r     <= 1'b0;
      mac0Col_r     <= 1'b0;
      mac0MdioIn_r  <= 1'b0;
      mac1RxClkEn_r <= 1'b0;
      mac1Rxd_r     <= 2'h0;
      mac1CrsDv_r   <= 1'b0;
      mac1MdioIn_r  <= 1'b0;
    end else begin
      // the shared pin clocks channel 0, and channel 1 too in dual RMII
      mac0RxClkEn_r <= mac0ClockEnable_r & clkRise[0];             // [RQ4]
      mac1RxClkEn_r <= mac1ClockEnable_r & isDual & clkRise[0];    // [RQ4]
      mac0TxClkEn_r <= mac0ClockEnable_r & isMii & clkRise[1];     // [RQ7]
      if (mac0ClockEnable_r) begin
        mac0RxDv_r   <= sRxDv;                                     // [RQ2]
        mac0MdioIn_r <= sMdio0;
        if (isMii) begin
          mac0Rxd_r  <= sRxd;                                      // [RQ7]
          mac0RxEr_r <= sRxErr;
          mac0Crs_r  <= sCrs;
          mac0Col_r  <= sCol;
        end else begin
          mac0Rxd_r  <= {2'h0, sRxd[1:0]};                         // [RQ8]
          mac0RxEr_r <= 1'b0;                                      // [RQ5]
          mac0Crs_r  <= 1'b0;                                      // [RQ17]
          mac0Col_r  <= 1'b0;                                      // [RQ17]
        end
      end else begin
        mac0Rxd_r    <= 4'h0;
        mac0RxDv_r   <= 1'b0;
        mac0RxEr_r   <= 1'b0;
        mac0Crs_r    <= 1'b0;
        mac0Col_r    <= 1'b0;
        mac0MdioIn_r <= 1'b0;
      end
      if (mac1ClockEnable_r && isDual) begin
        mac1Rxd_r    <= sRxd[3:2];                                 // [RQ9]
        mac1CrsDv_r  <= sRxErr;                                    // [RQ5]
        mac1MdioIn_r <= sMdio1;                                    // [RQ9]
      end else begin
        mac1Rxd_r    <= 2'h0;                                      // [RQ17]
        mac1CrsDv_r  <= 1'b0;
        mac1MdioIn_r <= 1'b0;
      end
    end
  end

  // transmit direction: MACs towards the pins, frozen in low power
  always @(posedge clk) begin
    if (sys_rst) begin
      txdPin_r                    <= 4'h0;
      txEnPin_r                   <= 1'b0;
      txerrOrCh1TxenPin_r         <= 1'b0;
      txclkOrCh1MgmtClockPinOut_r <= 1'b0;
      txclkOrCh1MgmtClockPinOe_r  <= 1'b0;
      mdcPin_r                    <= 1'b0;
      mdioPinOut_r                <= 1'b0;
      mdioPinOe_r                 <= 1'b0;
      ch1MgmtDataPinOut_r         <= 1'b0;
      ch1MgmtDataPinOe_r          <= 1'b0;
    end else if (!lowPowerMode) begin                              // [RQ13]
      txEnPin_r    <= run0 & mac0TxEn;                             // [RQ2]
      mdcPin_r     <= run0 & mac0Mdc;
      mdioPinOut_r <= run0 & mac0MdioOut;
      mdioPinOe_r  <= run0 & mac0MdioOe;
      if (isMii) begin
        txdPin_r            <= run0 ? mac0Txd : 4'h0;              // [RQ7]
        txerrOrCh1TxenPin_r <= run0 & mac0LpiActive;               // [RQ6]
      end else if (isDual) begin
        txdPin_r            <= {run1 ? mac1Txd : 2'h0,
                                run0 ? mac0Txd[1:0] : 2'h0};       // [RQ9]
        txerrOrCh1TxenPin_r <= run1 & mac1TxEn;                    // [RQ9]
      end else begin
        txdPin_r            <= {2'h0, run0 ? mac0Txd[1:0] : 2'h0}; // [RQ8]
        txerrOrCh1TxenPin_r <= 1'b0;                               // [RQ17]
      end
      // the transmit clock pin turns into channel 1 MDC in dual RMII
      txclkOrCh1MgmtClockPinOe_r  <= isDual;                       // [RQ9]
      txclkOrCh1MgmtClockPinOut_r <= run1 & mac1Mdc;               // [RQ9]
      ch1MgmtDataPinOut_r         <= run1 & mac1MdioOut;           // [RQ10]
      ch1MgmtDataPinOe_r          <= run1 & mac1MdioOe;
    end
  end
endmodule

// *** tb/mrps_sel_sva.sv ***
// assertions on the pin selector ports
module mrps_sel_sva (
  input logic       clk,
  input logic       sys_rst,
  input logic       psel,
  input logic       penable,
  input logic       pready,
  input logic       pslverr,
  input logic       lowPowerMode,
  input logic       mac0ClockEnable_r,
  input logic       mac1ClockEnable_r,
  input logic       mac0HwReset_r,
  input logic       mac1HwReset_r,
  input logic [3:0] mac0Txd,
  input logic       mac0TxEn,
  input logic [1:0] mac1Txd,
  input logic       mac1TxEn,
  input logic [3:0] txdPin_r,
  input logic       txEnPin_r,
  input logic       txerrOrCh1TxenPin_r,
  input logic       txclkOrCh1MgmtClockPinOe_r,
  input logic       mac0RxClkEn_r
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // a channel counts as running when out of reset, clocked and awake; channel 1 also needs dual RMII
  wire run0 = !mac0HwReset_r && mac0ClockEnable_r && !lowPowerMode;
  wire run1 = !mac1HwReset_r && mac1ClockEnable_r && !lowPowerMode
    && txclkOrCh1MgmtClockPinOe_r;

  a_ready_after_setup:
    assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle:
    assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_tx0_quiet_reset:
    assert property ((mac0HwReset_r && !lowPowerMode)[*2]
      |-> !txEnPin_r && txdPin_r[1:0] == 2'h0)
    else $error("channel 0 transmits while in reset");
  a_txd0_follow:
    assert property ($past(run0) && run0 |-> txEnPin_r == $past(mac0TxEn)
      && txdPin_r[1:0] == $past(mac0Txd[1:0]))
    else $error("channel 0 transmit pins do not follow");
  a_ch1_tx_route:
    assert property ($past(run1) && run1
      |-> txerrOrCh1TxenPin_r == $past(mac1TxEn)
      && txdPin_r[3:2] == $past(mac1Txd))
    else $error("channel 1 transmit pins misrouted");
  a_lp_freeze:
    assert property ($past(lowPowerMode)
      |-> $stable(txdPin_r) && $stable(txEnPin_r))
    else $error("pins changed in low power mode");
  a_rxclk_pulse:
    assert property (mac0RxClkEn_r |=> !mac0RxClkEn_r)
    else $error("receive clock enable longer than one cycle");

  c_dual_run: cover property (run1);
  c_low_power: cover property (lowPowerMode && mac0ClockEnable_r);
  c_refused: cover property (pslverr);
endmodule

bind mrps_selector mrps_sel_sva chk_u (
  .clk, .sys_rst, .psel, .penable, .pready, .pslverr, .lowPowerMode,
  .mac0ClockEnable_r, .mac1ClockEnable_r, .mac0HwReset_r, .mac1HwReset_r,
  .mac0Txd, .mac0TxEn, .mac1Txd, .mac1TxEn, .txdPin_r, .txEnPin_r,
  .txerrOrCh1TxenPin_r, .txclkOrCh1MgmtClockPinOe_r, .mac0RxClkEn_r);

// *** tb/mrps_phy_model.sv ***
// far-side phy model: free clocks and receive pins
module mrps_phy_model (
  output logic       refClk,
  output logic       txClk,
  output logic [7:0] rxPins,
  input  logic [7:0] rxWant
);
  timeunit 1ns;
  timeprecision 100ps;
  // reference clock runs free, offset from the system clock
  initial begin
    refClk = 1'h0;
    #3.3;
    forever #40 refClk = ~refClk;
  end
  initial begin
    txClk = 1'h0;
    #17.1;
    forever #40 txClk = ~txClk;
  end
  initial rxPins = 8'h00;
  // pins change on the falling edge, away from the sampling edge
  always @(negedge refClk) rxPins <= rxWant;
endmodule

// *** tb/mrps_selector_test.sv ***
// self-checking bench for the mii / rmii pin selector
module mrps_selector_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic        lowPowerMode = 1'h0;
  logic        e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] q;
  logic [31:0] rng = 32'h00015bb7;
  logic [14:0] drv = 15'h0000;
  logic [7:0]  rxWant = 8'h00;
  logic [12:0] snap;
  int          miscompares = 0;
  int          compares = 0;
  int          cyc = 0;
  int          p0, p1, p2;
  wire [31:0]  prdata;
  wire         pready, pslverr, hw0, hw1, refClk, txClk, ce0, ce1;
  wire         rc0, tc0, rc1, dv0, er0, crs0, col0, dv1, mi0, mi1;
  wire         tckO, tckE, txEn, txEr, mdc, mdO, mdE, m1O, m1E;
  wire [3:0]   rxd0, txd;
  wire [1:0]   rxd1;
  wire [7:0]   rxPins;
  wire [12:0]  tx = {m1E, m1O, tckE, tckO, mdc, mdE, mdO, txEr, txEn, txd};
  wire [10:0]  rx = {dv1, rxd1, col0, crs0, er0, dv0, rxd0};

  mrps_phy_model phy_u (.refClk(refClk), .txClk(txClk), .rxPins(rxPins),
    .rxWant(rxWant));
  // shared pins resolve here; management data lines are pulled up
  mrps_selector #(.DUAL_CH(1), .LOSS_CYC(20)) dut_u (
    .clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .lowPowerMode,
    .mac0ClockEnable_r(ce0), .mac1ClockEnable_r(ce1),
    .mac0HwReset_r(hw0), .mac1HwReset_r(hw1),
    .mac0RxClkEn_r(rc0), .mac0TxClkEn_r(tc0), .mac0Rxd_r(rxd0),
    .mac0RxDv_r(dv0), .mac0RxEr_r(er0), .mac0Crs_r(crs0), .mac0Col_r(col0),
    .mac0MdioIn_r(mi0), .mac0Txd(drv[3:0]), .mac0TxEn(drv[4]),
    .mac0LpiActive(drv[5]), .mac0Mdc(drv[6]), .mac0MdioOut(drv[7]),
    .mac0MdioOe(drv[8]), .mac1RxClkEn_r(rc1), .mac1Rxd_r(rxd1),
    .mac1CrsDv_r(dv1), .mac1MdioIn_r(mi1), .mac1Txd(drv[10:9]),
    .mac1TxEn(drv[11]), .mac1Mdc(drv[12]), .mac1MdioOut(drv[13]),
    .mac1MdioOe(drv[14]), .sharedRxRefClockPin(refClk),
    .rxdPin(rxPins[3:0]), .rxDvPin(rxPins[4]), .rxerrOrCh1DvPin(rxPins[5]),
    .crsPin(rxPins[6]), .colPin(rxPins[7]),
    .txclkOrCh1MgmtClockPinIn(tckE ? tckO : txClk),
    .txclkOrCh1MgmtClockPinOut_r(tckO), .txclkOrCh1MgmtClockPinOe_r(tckE),
    .txdPin_r(txd), .txEnPin_r(txEn), .txerrOrCh1TxenPin_r(txEr),
    .mdcPin_r(mdc), .mdioPinIn(mdE ? mdO : 1'h1), .mdioPinOut_r(mdO),
    .mdioPinOe_r(mdE), .ch1MgmtDataPinIn(m1E ? m1O : 1'h1),
    .ch1MgmtDataPinOut_r(m1O), .ch1MgmtDataPinOe_r(m1E));

  always #4 clk = ~clk;

  always @(posedge clk) begin
    p0 += rc0;
    p1 += tc0;
    p2 += rc1;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // expected pins: {ch1 mdio oe/out, txclk oe/out, mdc, mdio oe/out,
  // txer, txen, txd}
  function automatic logic [12:0] expTx(input logic [1:0] c,
                                        input logic [14:0] d);
    logic [12:0] t;
    t = {4'h0, d[6], d[8], d[7], d[5], d[4], d[3:0]};
    if (c != 2'h0) begin
      t[5] = 1'h0;
      t[3:2] = 2'h0;
    end
    if (c == 2'h3) begin
      t[12:9] = {d[14:13], 1'h1, d[12]};
      t[5] = d[11];
      t[3:2] = d[10:9];
    end
    return t;
  endfunction

  task chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task stop_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do
      @(posedge clk);
    while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic setup(input logic [1:0] en, input logic [2:0] md,
                       input logic [1:0] c);
    apb(1'h1, 12'h008, {30'h0, en});
    apb(1'h1, 12'h000, {29'h0, md});
    repeat (3) @(posedge clk);
    #1 chk(hw0, 1'h1);
    chk({ce1, ce0}, en);
    apb(1'h0, 12'h00c, 32'h0);
    while (q[2] !== 1'h1)
      apb(1'h0, 12'h00c, 32'h0);
    chk(q[5:4], c);
    apb(1'h1, 12'h000, {31'h0, md[0]});
    repeat (3) @(posedge clk);
    #1 chk({hw1 & en[1], hw0}, 2'h0);
  endtask

  task automatic burst(input logic [1:0] c);
    logic [12:0] t;
    logic [10:0] x;
    p0 = 0;
    p1 = 0;
    p2 = 0;
    repeat (8) begin
      @(posedge clk);
      rng = xs(rng);
      drv <= rng[14:0];
      rxWant <= rng[31:24];
      @(posedge clk);
      #1 chk(tx, expTx(c, drv));
      repeat (24) @(posedge clk);
      x = {rxWant[5], rxWant[3:2], rxWant};
      if (c != 2'h3)
        x[10:8] = 3'h0;
      if (c != 2'h0) begin
        x[7:5] = 3'h0;
        x[3:2] = 2'h0;
      end
      #1 chk(rx, x);
      t = expTx(c, drv);
      t[1:0] = {c == 2'h3 && (!t[12] || t[11]), !t[7] || t[6]};
      chk({mi1, mi0}, t[1:0]);
    end
    chk(p0 > 18 && p0 < 23, 1'h1);
    chk(c == 2'h0 ? p1 > 18 && p1 < 23 : p1 == 0, 1'h1);
    chk(c == 2'h3 ? p2 > 18 && p2 < 23 : p2 == 0, 1'h1);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'h0;
    apb(1'h1, 12'h004, 32'hffffffff);
    chk(e, 1'h1);
    apb(1'h0, 12'h000, 32'h0);
    chk(q, 32'h6);
    apb(1'h0, 12'h008, 32'h0);
    chk(q, 32'h0);
    apb(1'h1, 12'h008, 32'h3);
    apb(1'h0, 12'h00c, 32'h0);
    chk(q[6:4], 3'h4);
    setup(2'h1, 3'h2, 2'h0);
    burst(2'h0);
    setup(2'h1, 3'h3, 2'h1);
    burst(2'h1);
    setup(2'h3, 3'h7, 2'h3);
    burst(2'h3);
    // stopping channel 1 clock must keep it in reset until set up again
    apb(1'h1, 12'h008, 32'h1);
    repeat (3) @(posedge clk);
    #1 chk(hw1, 1'h1);
    apb(1'h1, 12'h008, 32'h3);
    repeat (3) @(posedge clk);
    #1 chk(hw1, 1'h1);
    setup(2'h3, 3'h7, 2'h3);
    @(posedge clk);
    lowPowerMode <= 1'h1;
    repeat (3) @(posedge clk);
    #1 snap = tx;
    repeat (4) begin
      @(posedge clk);
      rng = xs(rng);
      drv <= rng[14:0];
    end
    repeat (2) @(posedge clk);
    #1 chk(tx, snap);
    stop_test();
  end
endmodule
